// file: core/ppp_pkg.sv
// Constants, types and address map of the parallel programming port
package ppp_pkg;
    // Memory geometry
    localparam int FLASH_WORDS = 65536;
    localparam int FLASH_AW    = 16;
    localparam int PAGE_WORDS  = 128;
    localparam int PAGE_AW     = 7;
    localparam int EE_BYTES    = 4096;
    localparam int EE_AW       = 12;
    localparam int EE_PAGE     = 8;
    localparam int EE_PAGE_AW  = 3;

    // Command bytes
    localparam logic [7:0] CMD_NOP         = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EE    = 8'h11;
    localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
    localparam logic [7:0] CMD_READ_EE     = 8'h03;

    // Action select codes for the load strobe
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // Entry pattern on page latch, action select hi/lo, byte select one
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;

    // Reset and erase values
    localparam logic [15:0] ERASED_WORD  = 16'hffff;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [7:0]  LOCK_ERASED  = 8'hff;
    localparam logic [7:0]  FUSE_LOW_RST = 8'hff;

    // Register map, byte addresses
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_ADDR    = 8'h08;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    // Field positions
    localparam int CTRL_PRESERVE = 0;
    localparam int ST_MODE       = 0;
    localparam int ST_READY      = 1;
    localparam int ST_DIRTY      = 2;
    localparam int ST_CMD_LSB    = 8;
    localparam int ST_FUSE_LSB   = 16;
    localparam int ST_LOCK_LSB   = 24;

    typedef struct packed {
        logic       hv_reset;
        logic       page_latch_strobe;
        logic       action_select_hi;
        logic       action_select_lo;
        logic       byte_select_one;
        logic       byte_select_two;
        logic       load_strobe;
        logic       write_n;
        logic       output_enable_n;
        logic [7:0] data;
    } ppp_pins_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG_FLASH, ST_PROG_EE, ST_PROG_FUSE} ppp_state_t;
endpackage : ppp_pkg

// file: core/ppp_port.sv
// Parallel programming port with AXI4-Lite status and control
//
// Summary of operation
// - Dropping reset high voltage leaves programming mode.
// - Command and address persist across operations.
// - Chip erase clears memories, locks freed last.
// - Preserve fuse keeps EEPROM through chip erase.
// - Action 10, load strobe captures command.
// - Action 00 loads address low/high byte.
// - Action 01 loads data low/high byte.
// - Falling write starts command, busy until done.
// - Page latch stores data word in buffer.
// - Low address bits word, upper bits page.
// - Write flash command programs whole page.
// - No-operation command clears internal write state.
// - Write EEPROM programs page, byte select low.
// - Read flash presents low/high byte.
// - Read EEPROM presents addressed byte.
// - Write fuse stores data low byte.
// - Ready/busy low busy, high ready.
// - Data bus driven only with output enable.
`timescale 1ns/1ns
`default_nettype none
module ppp_port (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ppp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ppp_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire ppp_pkg::ppp_pins_t        pins,
    output logic [7:0]                     data_out,
    output logic                           data_oe_n,
    output logic                           ready_busy
);
    ppp_pkg::ppp_pins_t  sync1;
    ppp_pkg::ppp_pins_t  sync2;
    ppp_pkg::ppp_pins_t  sync3;
    ppp_pkg::ppp_state_t state;
    ppp_pkg::ppp_state_t next_state;
    logic [15:0]         flash_mem [ppp_pkg::FLASH_WORDS];
    logic [7:0]          ee_mem    [ppp_pkg::EE_BYTES];
    logic [15:0]         page_buf  [ppp_pkg::PAGE_WORDS];
    logic                prog_mode;
    logic [7:0]          cmd;
    logic [15:0]         addr;
    logic [7:0]          data_lo;
    logic [7:0]          data_hi;
    logic [7:0]          fuse_low;
    logic [7:0]          lock_bits;
    logic                page_dirty;
    logic                preserve_fuse;
    logic [15:0]         idx;
    logic                load_rise;
    logic                latch_rise;
    logic                write_fall;
    logic                hv_rise;
    logic                ready;
    logic                accept;
    logic                aw_taken;
    logic                w_taken;
    logic [ppp_pkg::AXI_AW-1:0] wr_addr;
    logic [31:0]         wr_data;
    logic [3:0]          wr_strb;

    // Flash word address: page from the address, word from the index
    function automatic logic [15:0] page_word(input logic [15:0] a, input logic [15:0] i);
        page_word = {a[15:ppp_pkg::PAGE_AW], i[ppp_pkg::PAGE_AW-1:0]};
    endfunction : page_word

    // EEPROM byte address: page from the address, byte from the index
    function automatic logic [ppp_pkg::EE_AW-1:0] ee_byte(input logic [15:0] a, input logic [15:0] i);
        ee_byte = {a[ppp_pkg::EE_AW-1:ppp_pkg::EE_PAGE_AW], i[ppp_pkg::EE_PAGE_AW-1:0]};
    endfunction : ee_byte

    // Pin synchronisers; third stage only feeds edge detection
    always_ff @(posedge aclk) begin
        sync1 <= pins;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    assign load_rise  = sync2.load_strobe & ~sync3.load_strobe;
    assign latch_rise = sync2.page_latch_strobe & ~sync3.page_latch_strobe;
    assign write_fall = ~sync2.write_n & sync3.write_n;
    assign hv_rise    = sync2.hv_reset & ~sync3.hv_reset;
    assign ready      = (state == ppp_pkg::ST_IDLE);
    assign accept     = prog_mode & ready;

    // Mode entry latches the pattern as high voltage arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_mode <= 1'b0;
        end else if (!sync2.hv_reset) begin
            prog_mode <= 1'b0;
        end else if (hv_rise) begin
            prog_mode <= ({sync2.page_latch_strobe, sync2.action_select_hi, sync2.action_select_lo,
                           sync2.byte_select_one} == ppp_pkg::ENTRY_PATTERN);
        end
    end

    // Command, address and data loads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd     <= ppp_pkg::CMD_NOP;
            addr    <= 16'h0000;
            data_lo <= 8'h00;
            data_hi <= 8'h00;
        end else if (accept && load_rise) begin
            unique case ({sync2.action_select_hi, sync2.action_select_lo})
                ppp_pkg::ACT_CMD: begin
                    if (!sync2.byte_select_one) begin
                        cmd <= sync2.data;
                    end
                end
                ppp_pkg::ACT_ADDR: begin
                    if (sync2.byte_select_one) begin
                        addr[15:8] <= sync2.data;
                    end else begin
                        addr[7:0] <= sync2.data;
                    end
                end
                ppp_pkg::ACT_DATA: begin
                    if (sync2.byte_select_one) begin
                        data_hi <= sync2.data;
                    end else begin
                        data_lo <= sync2.data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Page buffer fill and its pending flag
    always_ff @(posedge aclk) begin
        if (accept && latch_rise) begin
            if (cmd == ppp_pkg::CMD_WRITE_EE) begin
                page_buf[addr[ppp_pkg::EE_PAGE_AW-1:0]] <= {8'h00, data_lo};
            end else if (sync2.byte_select_one) begin
                page_buf[addr[ppp_pkg::PAGE_AW-1:0]] <= {data_hi, data_lo};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_dirty <= 1'b0;
        end else if (accept && load_rise && sync2.action_select_hi && !sync2.action_select_lo
                     && sync2.data == ppp_pkg::CMD_NOP) begin
            page_dirty <= 1'b0;
        end else if (accept && latch_rise) begin
            page_dirty <= 1'b1;
        end else if (state != ppp_pkg::ST_IDLE && next_state == ppp_pkg::ST_IDLE) begin
            page_dirty <= 1'b0;
        end
    end

    // Operation sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ppp_pkg::ST_IDLE: begin
                if (accept && write_fall) begin
                    if (cmd == ppp_pkg::CMD_CHIP_ERASE) begin
                        next_state = ppp_pkg::ST_ERASE;
                    end else if (cmd == ppp_pkg::CMD_WRITE_FLASH) begin
                        next_state = ppp_pkg::ST_PROG_FLASH;
                    end else if (cmd == ppp_pkg::CMD_WRITE_EE && !sync2.byte_select_one) begin
                        next_state = ppp_pkg::ST_PROG_EE;
                    end else if (cmd == ppp_pkg::CMD_WRITE_FUSE) begin
                        next_state = ppp_pkg::ST_PROG_FUSE;
                    end
                end
            end
            ppp_pkg::ST_ERASE: begin
                if (idx == 16'(ppp_pkg::FLASH_WORDS - 1)) begin
                    next_state = ppp_pkg::ST_IDLE;
                end
            end
            ppp_pkg::ST_PROG_FLASH: begin
                if (idx == 16'(ppp_pkg::PAGE_WORDS - 1)) begin
                    next_state = ppp_pkg::ST_IDLE;
                end
            end
            ppp_pkg::ST_PROG_EE: begin
                if (idx == 16'(ppp_pkg::EE_PAGE - 1)) begin
                    next_state = ppp_pkg::ST_IDLE;
                end
            end
            ppp_pkg::ST_PROG_FUSE: begin
                next_state = ppp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !prog_mode) begin
            state      <= ppp_pkg::ST_IDLE;
            idx        <= 16'h0000;
            ready_busy <= 1'b1;
        end else begin
            state      <= next_state;
            idx        <= (state == next_state) ? idx + 16'h0001 : 16'h0000;
            ready_busy <= (next_state == ppp_pkg::ST_IDLE);
        end
    end

    // Array writes for erase and page programming
    always_ff @(posedge aclk) begin
        if (state == ppp_pkg::ST_ERASE) begin
            flash_mem[idx] <= ppp_pkg::ERASED_WORD;
            if (!preserve_fuse && idx < 16'(ppp_pkg::EE_BYTES)) begin
                ee_mem[idx[ppp_pkg::EE_AW-1:0]] <= ppp_pkg::ERASED_BYTE;
            end
        end else if (state == ppp_pkg::ST_PROG_FLASH) begin
            flash_mem[page_word(addr, idx)] <= page_buf[idx[ppp_pkg::PAGE_AW-1:0]];
        end else if (state == ppp_pkg::ST_PROG_EE) begin
            ee_mem[ee_byte(addr, idx)] <= page_buf[idx[ppp_pkg::EE_PAGE_AW-1:0]][7:0];
        end
    end

    // Fuse and lock bytes; locks released in the same cycle as the last flash word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_low  <= ppp_pkg::FUSE_LOW_RST;
            lock_bits <= ppp_pkg::LOCK_ERASED;
        end else if (state == ppp_pkg::ST_PROG_FUSE) begin
            fuse_low <= data_lo;
        end else if (state == ppp_pkg::ST_ERASE && next_state == ppp_pkg::ST_IDLE) begin
            lock_bits <= ppp_pkg::LOCK_ERASED;
        end
    end

    // Read path onto the data bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_oe_n <= 1'b1;
            data_out  <= 8'h00;
        end else begin
            data_oe_n <= ~(prog_mode && !sync2.output_enable_n
                           && (cmd == ppp_pkg::CMD_READ_FLASH || cmd == ppp_pkg::CMD_READ_EE));
            if (cmd == ppp_pkg::CMD_READ_EE) begin
                data_out <= sync2.byte_select_one ? 8'h00 : ee_mem[addr[ppp_pkg::EE_AW-1:0]];
            end else if (sync2.byte_select_one) begin
                data_out <= flash_mem[addr][15:8];
            end else begin
                data_out <= flash_mem[addr][7:0];
            end
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ppp_pkg::RESP_OKAY;
            aw_taken      <= 1'b0;
            w_taken       <= 1'b0;
            wr_addr       <= '0;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
            preserve_fuse <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_taken      <= 1'b1;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_taken      <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (aw_taken && w_taken && !s_axi_bvalid) begin
                aw_taken     <= 1'b0;
                w_taken      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == ppp_pkg::OFS_CTRL) begin
                    s_axi_bresp <= ppp_pkg::RESP_OKAY;
                    if (wr_strb[0]) begin
                        preserve_fuse <= wr_data[ppp_pkg::CTRL_PRESERVE];
                    end
                end else if (wr_addr == ppp_pkg::OFS_STATUS || wr_addr == ppp_pkg::OFS_ADDR) begin
                    s_axi_bresp <= ppp_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= ppp_pkg::RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= ppp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= ppp_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            if (s_axi_araddr == ppp_pkg::OFS_CTRL) begin
                s_axi_rdata[ppp_pkg::CTRL_PRESERVE] <= preserve_fuse;
            end else if (s_axi_araddr == ppp_pkg::OFS_STATUS) begin
                s_axi_rdata[ppp_pkg::ST_MODE]                   <= prog_mode;
                s_axi_rdata[ppp_pkg::ST_READY]                  <= ready;
                s_axi_rdata[ppp_pkg::ST_DIRTY]                  <= page_dirty;
                s_axi_rdata[ppp_pkg::ST_CMD_LSB+:8]             <= cmd;
                s_axi_rdata[ppp_pkg::ST_FUSE_LSB+:8]            <= fuse_low;
                s_axi_rdata[ppp_pkg::ST_LOCK_LSB+:8]            <= lock_bits;
            end else if (s_axi_araddr == ppp_pkg::OFS_ADDR) begin
                s_axi_rdata[15:0] <= addr;
            end else begin
                s_axi_rresp <= ppp_pkg::RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : ppp_port
`default_nettype wire

// file: verif/ppp_port_assertions.sv
// Concurrent checks on the programming port boundary
`timescale 1ns/1ns
`default_nettype none
module ppp_port_assertions (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire ppp_pkg::ppp_pins_t pins,
    input wire logic               data_oe_n,
    input wire logic               ready_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    busy_has_cause_a: assert property ($fell(ready_busy) |-> !$past(pins.write_n, 2))
        else $error("busy began without a write strobe");
    exit_idle_a: assert property (!pins.hv_reset [*6] |-> ready_busy && data_oe_n)
        else $error("port active outside programming mode");
    oe_follow_a: assert property ($fell(data_oe_n) |-> !$past(pins.output_enable_n, 2))
        else $error("bus driven without output enable");
    oe_release_a: assert property ($rose(pins.output_enable_n) |-> ##[1:5] data_oe_n)
        else $error("bus not released after output enable");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == ppp_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    cover property ($fell(ready_busy));
    cover property (!data_oe_n);
    cover property (s_axi_bvalid && s_axi_bresp == ppp_pkg::RESP_DECERR);
endmodule : ppp_port_assertions
`default_nettype wire

// file: verif/ppp_programmer.sv
// Behavioural external programmer driving the port pins
`timescale 1ns/1ns
`default_nettype none
module ppp_programmer (
    input  wire logic               aclk,
    input  wire logic [7:0]         data_out,
    input  wire logic               data_oe_n,
    input  wire logic               ready_busy,
    output wire ppp_pkg::ppp_pins_t pins
);
    ppp_pkg::ppp_pins_t p = '{write_n: 1'b1, output_enable_n: 1'b1, default: '0};
    // Undriven bus shows inverted last value so stale data never matches
    assign pins = {p[16:8], !data_oe_n ? data_out : (p.output_enable_n ? p.data : ~p.data)};
    task automatic hold(input int n);
        repeat (n) @(posedge aclk);
    endtask : hold
    task automatic pulse(input int b);
        p[b] <= ~p[b];
        hold(8);
        p[b] <= ~p[b];
        hold(8);
    endtask : pulse
    task automatic enter();
        p <= '{write_n: 1'b1, output_enable_n: 1'b1, default: '0};
        hold(8);
        p.hv_reset <= 1'b1;
        hold(260);
        hold(7520);
    endtask : enter
    task automatic leave();
        p.hv_reset <= 1'b0;
        hold(8);
    endtask : leave
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] v);
        {p.action_select_hi, p.action_select_lo, p.byte_select_one, p.data} <= {act, bs, v};
        hold(8);
        pulse(10);
    endtask : load
    task automatic latch();
        p.byte_select_one <= 1'b1;
        hold(8);
        pulse(15);
    endtask : latch
    task automatic read(input logic bs, output logic [8:0] got);
        p.byte_select_one <= bs;
        p.output_enable_n <= 1'b0;
        hold(8);
        got = {data_oe_n, pins.data};
        p.output_enable_n <= 1'b1;
        hold(8);
    endtask : read
    task automatic write(input logic bs, output int lows);
        p.byte_select_one <= bs;
        hold(8);
        p.write_n <= 1'b0;
        lows = 0;
        // Waits for ready before anything else is loaded
        for (int i = 0; i < 70000 && (i < 12 || !ready_busy); i++) begin
            hold(1);
            if (i == 8) p.write_n <= 1'b1;
            lows += int'(!ready_busy);
        end
        hold(8);
    endtask : write
endmodule : ppp_programmer
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic                       aclk = 1'b0;
    logic                       aresetn = 1'b0;
    logic [ppp_pkg::AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic                       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0]                s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0]                 s_axi_wstrb = 4'hf;
    logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]                 s_axi_bresp, s_axi_rresp, r;
    logic [7:0]                 data_out, ev, fv;
    logic                       data_oe_n, ready_busy;
    wire ppp_pkg::ppp_pins_t    pins;
    int                         bad_count = 0, check_count = 0, n;
    logic [8:0]                 got, pg;
    logic [11:0]                ea;
    logic [6:0]                 wi [4];
    logic [15:0]                wv [4];
    always #20 aclk = ~aclk;
    ppp_port dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .data_out, .data_oe_n,
        .ready_busy);
    ppp_programmer prog_u (.aclk, .data_out, .data_oe_n, .ready_busy, .pins);
    function automatic logic [15:0] word_addr(input logic [8:0] page, input logic [6:0] w);
        return {page, w};
    endfunction : word_addr
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'b11};
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        {v, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic cmd(input logic [7:0] c);
        prog_u.load(ppp_pkg::ACT_CMD, 1'b0, c);
    endtask : cmd
    task automatic addr(input logic [15:0] a);
        prog_u.load(ppp_pkg::ACT_ADDR, 1'b1, a[15:8]);
        prog_u.load(ppp_pkg::ACT_ADDR, 1'b0, a[7:0]);
    endtask : addr
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        repeat (95000) @(posedge aclk);
        bad_count++;
        complete_run();
    end
    initial begin
        n = $urandom(32'h80db);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK({ready_busy, data_oe_n}, 2'b11)
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK(d[ppp_pkg::ST_MODE], 1'b0)
        axi_rd(8'hfc, d, r);
        `CHK({r, d}, {ppp_pkg::RESP_DECERR, 32'h0})
        axi_wr(8'h40, 32'h1, r);
        `CHK(r, ppp_pkg::RESP_DECERR)
        prog_u.enter();
        ea = 12'($urandom);
        ev = 8'($urandom);
        cmd(ppp_pkg::CMD_WRITE_EE);
        addr({4'h0, ea});
        prog_u.load(ppp_pkg::ACT_DATA, 1'b0, ev);
        prog_u.latch();
        prog_u.write(1'b0, n);
        `CHK(n >= ppp_pkg::EE_PAGE, 1'b1)
        axi_wr(ppp_pkg::OFS_CTRL, 32'h1, r);
        axi_rd(ppp_pkg::OFS_CTRL, d, r);
        `CHK(d[ppp_pkg::CTRL_PRESERVE], 1'b1)
        cmd(ppp_pkg::CMD_CHIP_ERASE);
        fork
            prog_u.write(1'b0, n);
            begin prog_u.hold(100); cmd(ppp_pkg::CMD_READ_FLASH); end
        join
        `CHK(n >= ppp_pkg::FLASH_WORDS, 1'b1)
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK({d[31:24], d[15:8], d[0]}, {ppp_pkg::LOCK_ERASED, ppp_pkg::CMD_CHIP_ERASE, 1'b1})
        cmd(ppp_pkg::CMD_READ_EE);
        addr({4'h0, ea});
        prog_u.read(1'b0, got);
        `CHK(got, {1'b0, ev})
        cmd(ppp_pkg::CMD_READ_FLASH);
        addr(16'($urandom));
        prog_u.read(1'b1, got);
        `CHK(got, {1'b0, ppp_pkg::ERASED_BYTE})
        pg = 9'($urandom);
        cmd(ppp_pkg::CMD_WRITE_FLASH);
        for (int k = 0; k < 4; k++) begin
            wi[k] = (k == 3) ? 7'h7f : 7'(k * 40 + $urandom_range(7));
            wv[k] = 16'($urandom);
            addr(word_addr(pg, wi[k]));
            prog_u.load(ppp_pkg::ACT_DATA, 1'b0, wv[k][7:0]);
            prog_u.load(ppp_pkg::ACT_DATA, 1'b1, wv[k][15:8]);
            prog_u.latch();
        end
        axi_rd(ppp_pkg::OFS_ADDR, d, r);
        `CHK(d[15:0], word_addr(pg, 7'h7f))
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK(d[ppp_pkg::ST_DIRTY], 1'b1)
        prog_u.write(1'b0, n);
        `CHK(n >= ppp_pkg::PAGE_WORDS, 1'b1)
        cmd(ppp_pkg::CMD_NOP);
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK(d[ppp_pkg::ST_DIRTY], 1'b0)
        cmd(ppp_pkg::CMD_READ_FLASH);
        for (int k = 0; k < 4; k++) begin
            addr(word_addr(pg, wi[k]));
            prog_u.read(1'b0, got);
            `CHK(got, {1'b0, wv[k][7:0]})
            prog_u.read(1'b1, got);
            `CHK(got, {1'b0, wv[k][15:8]})
        end
        fv = 8'($urandom);
        cmd(ppp_pkg::CMD_WRITE_FUSE);
        prog_u.load(ppp_pkg::ACT_DATA, 1'b0, fv);
        prog_u.read(1'b0, got);
        `CHK(got[8], 1'b1)
        prog_u.write(1'b0, n);
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK(d[23:16], fv)
        prog_u.leave();
        axi_rd(ppp_pkg::OFS_STATUS, d, r);
        `CHK({d[ppp_pkg::ST_MODE], ready_busy}, 2'b01)
        complete_run();
    end
endmodule : tb
bind ppp_port ppp_port_assertions chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .data_oe_n, .ready_busy);
`default_nettype wire
